// ==== bench/jesd_link_param_status_regs_tb_top.sv ====
// Testbench of the link parameter and status register bank.
// Assumes the far-end model drives the framer and receiver levels.
`timescale 1ns/10ps
`default_nettype none
module jesd_link_param_status_regs_tb_top;
  import jlps_pkg::*;
  logic core_clk_i, resetn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i, ila_multiframe_i;
  logic [2:0] hsize_i;
  logic sync_n_i, serializer_pll_lock_i, converter_pll_lock_i, link_up_i;
  logic sysref_evt_i, sysref_realign_i, mode_64b66b_i, frame_end_i;
  logic substitute_ok_i, ila_did_slot_i, ila_octet_ins_o, eof_insert_o;
  logic serial_link_enable_o, irq_o, mon_on, p_ins, p_ila;
  logic [7:0] ila_octet_o, eof_comma_o, exp_did;
  logic [7:0] codes [4] = '{K28_7_CODE, K28_1_CODE, K28_5_CODE, K28_7_CODE};
  int mismatches = 0;
  int cmp_count = 0;

  jlps_regs uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .sync_n_i(sync_n_i),
    .serializer_pll_lock_i(serializer_pll_lock_i),
    .converter_pll_lock_i(converter_pll_lock_i), .link_up_i(link_up_i),
    .sysref_evt_i(sysref_evt_i), .sysref_realign_i(sysref_realign_i),
    .mode_64b66b_i(mode_64b66b_i), .frame_end_i(frame_end_i),
    .substitute_ok_i(substitute_ok_i), .ila_multiframe_i(ila_multiframe_i),
    .ila_did_slot_i(ila_did_slot_i), .ila_octet_o(ila_octet_o),
    .ila_octet_ins_o(ila_octet_ins_o), .eof_comma_o(eof_comma_o),
    .eof_insert_o(eof_insert_o), .serial_link_enable_o(serial_link_enable_o),
    .irq_o(irq_o));

  jlps_far_model far (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .serial_link_enable_i(serial_link_enable_o), .sync_n_o(sync_n_i),
    .link_up_o(link_up_i), .frame_end_o(frame_end_i),
    .substitute_ok_o(substitute_ok_i), .ila_multiframe_o(ila_multiframe_i),
    .ila_did_slot_o(ila_did_slot_i));

  always #50 core_clk_i = ~core_clk_i;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {18'h0, idx, 2'h0};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 40);
    rd = hrdata_o;
    if (hreadyout_o !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    check(name, rd, exp);
    check("hresp", hresp_o, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic pulse(input logic realign);
    @(posedge core_clk_i);
    if (realign) sysref_realign_i <= 1'b1;
    else sysref_evt_i <= 1'b1;
    @(posedge core_clk_i);
    sysref_realign_i <= 1'b0;
    sysref_evt_i <= 1'b0;
    #1;
  endtask

  // Framer outputs one cycle after their strobes
  always @(negedge core_clk_i) begin
    if (mon_on) begin
      check("eof_insert", eof_insert_o, p_ins);
      check("ila_ins", ila_octet_ins_o, p_ila);
      if (ila_octet_ins_o === 1'b1) check("ila_octet", ila_octet_o, exp_did);
    end
    p_ins = frame_end_i & substitute_ok_i & serial_link_enable_o & ~mode_64b66b_i;
    p_ila = ila_did_slot_i & (ila_multiframe_i == ILA_DID_MF);
  end

  initial begin
    #5_000_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    core_clk_i = 1'b0;
    resetn_i = 1'b0;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    serializer_pll_lock_i = 1'b0;
    converter_pll_lock_i = 1'b0;
    sysref_evt_i = 1'b0;
    sysref_realign_i = 1'b0;
    mode_64b66b_i = 1'b0;
    mon_on = 1'b0;
    exp_did = 8'h00;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd_chk("device_id", IDX_DEVICE_ID, 32'h0);
    rd_chk("eof_sel", IDX_EOF_SEL, 32'h0);
    rd_chk("status", IDX_STATUS, 32'h0);
    wr(IDX_DEVICE_ID, 32'hFFFF_FFA5);
    exp_did = 8'hA5;
    wr(12'h240, 32'h0000_005A);
    rd_chk("device_id", IDX_DEVICE_ID, 32'hA5);
    cyc(2);
    mon_on = 1'b1;
    // Every selection code, ending on a generic receiver choice
    for (int i = 0; i < 5; i++) begin
      wr(IDX_EOF_SEL, 32'(i % 4));
      cyc(2);
      check("eof_comma", eof_comma_o, codes[i % 4]);
      rd_chk("eof_sel", IDX_EOF_SEL, 32'(i % 4));
    end
    wr(IDX_EOF_SEL, 32'h1);
    serializer_pll_lock_i <= 1'b1;
    converter_pll_lock_i <= 1'b1;
    cyc(4);
    rd_chk("status", IDX_STATUS, 32'h05);
    wr(IDX_STATUS, 32'hFF);
    rd_chk("status", IDX_STATUS, 32'h05);
    wr(IDX_CTRL, 32'h1);
    cyc(20);
    check("enable", serial_link_enable_o, 1'b1);
    rd_chk("status", IDX_STATUS, 32'h65);
    pulse(1'b0);
    cyc(3);
    rd_chk("status", IDX_STATUS, 32'h6D);
    wr(IDX_STATUS, 32'h00);
    rd_chk("status", IDX_STATUS, 32'h6D);
    wr(IDX_STATUS, 32'h08);
    rd_chk("status", IDX_STATUS, 32'h65);
    pulse(1'b0);
    cyc(3);
    rd_chk("status", IDX_STATUS, 32'h65);
    pulse(1'b1);
    cyc(3);
    rd_chk("status", IDX_STATUS, 32'h75);
    check("irq_masked", irq_o, 1'b0);
    wr(IDX_IRQ_MASK, 32'h10);
    cyc(3);
    check("irq_raised", irq_o, 1'b1);
    wr(IDX_STATUS, 32'h10);
    cyc(3);
    check("irq_cleared", irq_o, 1'b0);
    rd_chk("status", IDX_STATUS, 32'h65);
    mode_64b66b_i <= 1'b1;
    cyc(24);
    mode_64b66b_i <= 1'b0;
    cyc(24);
    wr(IDX_CTRL, 32'h0);
    cyc(20);
    rd_chk("status", IDX_STATUS, 32'h05);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== bench/jlps_far_model.sv ====
// Far-end receiver and framer model for the link side of the bank.
// Assumes the core clock domain and the bank's link enable output.
`timescale 1ns/10ps
`default_nettype none
module jlps_far_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Link control from the bank
  input wire logic serial_link_enable_i,
  // Receiver levels
  output logic sync_n_o,
  output logic link_up_o,
  // Framer strobes
  output logic frame_end_o,
  output logic substitute_ok_o,
  output logic [1:0] ila_multiframe_o,
  output logic ila_did_slot_o
);
  logic [3:0] frm_cnt_r;
  logic [3:0] en_cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      frm_cnt_r <= 4'h0;
      en_cnt_r <= 4'h0;
    end else begin
      frm_cnt_r <= frm_cnt_r + 4'h1;
      if (!serial_link_enable_i) begin
        en_cnt_r <= 4'h0;
      end else if (en_cnt_r != 4'hF) begin
        en_cnt_r <= en_cnt_r + 4'h1;
      end
    end
  end
  // Receiver requests sync until the link has run a while
  assign sync_n_o = (en_cnt_r >= 4'h4);
  assign link_up_o = (en_cnt_r >= 4'h8);
  assign frame_end_o = frm_cnt_r[0];
  assign substitute_ok_o = frm_cnt_r[1];
  assign ila_did_slot_o = (frm_cnt_r[1:0] == 2'h2);
  assign ila_multiframe_o = frm_cnt_r[3:2];
endmodule
`default_nettype wire

// ==== inc/jlps_pkg.sv ====
// Package for the link parameter and status register bank.
// Assumes a 32-bit AHB-Lite register bus and a 10 MHz core clock.
package jlps_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [11:0] IDX_DEVICE_ID = 12'h206;
  localparam logic [11:0] IDX_EOF_SEL = 12'h207;
  localparam logic [11:0] IDX_STATUS = 12'h208;
  localparam logic [11:0] IDX_CTRL = 12'h2F0;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h2F1;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 12;
  // Reset values
  localparam logic [7:0] RST_DEVICE_ID = 8'h00;
  localparam logic [1:0] RST_EOF_SEL = 2'h0;
  // Status and control bit positions
  localparam int ST_LINK_UP = 6;
  localparam int ST_SYNC = 5;
  localparam int ST_REALIGN = 4;
  localparam int ST_PHASE_SET = 3;
  localparam int ST_SPLL = 2;
  localparam int ST_CPLL = 0;
  localparam int CTRL_ENABLE = 0;
  // End-of-frame selection codes and comma characters
  localparam logic [1:0] EOF_K28_7 = 2'h0;
  localparam logic [1:0] EOF_K28_1 = 2'h1;
  localparam logic [1:0] EOF_K28_5 = 2'h2;
  localparam logic [7:0] K28_7_CODE = 8'hFC;
  localparam logic [7:0] K28_1_CODE = 8'h3C;
  localparam logic [7:0] K28_5_CODE = 8'hBC;
  // Multiframe of the alignment sequence that carries the identifier
  localparam logic [1:0] ILA_DID_MF = 2'h1;
  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE = 1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic sync_n;
    logic spll_lock;
    logic cpll_lock;
  } jlps_live_t;

  typedef struct packed {
    logic [7:0] k_code;
    logic insert;
  } jlps_eof_t;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_RD_FETCH
  } jlps_bus_t;
endpackage

// ==== logic/jlps_eof_sel.sv ====
// Combinational end-of-frame comma selection and insertion gate.
// Assumes frame-end and permit strobes from the 8B/10B framer.
`timescale 1ns/10ps
`default_nettype none
module jlps_eof_sel
  import jlps_pkg::*;
(
  // Configuration
  input wire logic [1:0] select_i,
  input wire logic link_enable_i,
  input wire logic mode_64b66b_i,
  // Framer strobes
  input wire logic frame_end_i,
  input wire logic substitute_ok_i,
  // Result
  output jlps_eof_t eof_o
);
  logic [7:0] code_sel;

  // Reserved value falls back to the default comma
  assign code_sel = (select_i == EOF_K28_1) ? K28_1_CODE :
                    (select_i == EOF_K28_5) ? K28_5_CODE : K28_7_CODE;
  assign eof_o.k_code = code_sel;
  // Substitute only where allowed and only in 8B/10B modes
  assign eof_o.insert = link_enable_i & frame_end_i & substitute_ok_i & ~mode_64b66b_i;
endmodule
`default_nettype wire

// ==== logic/jlps_regs.sv ====
// Link parameter and status register bank with AHB-Lite slave.
// Assumes a single-slave bus, word transfers and same-clock link logic.
//
// Overview of operation
// - Identifier goes into second alignment multiframe
// - Selection 0,1,2 picks K28.7, K28.1, K28.5
// - Comma substituted opportunistically at permitted frame ends
// - Comma selection ignored in 64B/66B modes
// - Bit 6 shows link established
// - Bit 5 shows current SYNC~ level
// - Bit 4 sticky on SYSREF realignment, write one clears
// - Bit 3 set by first SYSREF after enable
// - Write one clears bit 3, zero keeps
// - Bit 2 shows serializer PLL lock
// - Bit 0 shows converter PLL lock
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module jlps_regs
  import jlps_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Live conditions from pins
  input wire logic sync_n_i,
  input wire logic serializer_pll_lock_i,
  input wire logic converter_pll_lock_i,
  // Same-clock link events
  input wire logic link_up_i,
  input wire logic sysref_evt_i,
  input wire logic sysref_realign_i,
  input wire logic mode_64b66b_i,
  // Framer side
  input wire logic frame_end_i,
  input wire logic substitute_ok_i,
  input wire logic [1:0] ila_multiframe_i,
  input wire logic ila_did_slot_i,
  output logic [7:0] ila_octet_o,
  output logic ila_octet_ins_o,
  output logic [7:0] eof_comma_o,
  output logic eof_insert_o,
  // Control and interrupt
  output logic serial_link_enable_o,
  output logic irq_o
);
  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
    hits = (addr[IDX_LSB +: IDX_W] == idx) && (addr[IDX_LSB-1:0] == '0);
  endfunction

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] addr);
    idx_of = addr[IDX_LSB +: IDX_W];
  endfunction

  jlps_bus_t bus_r;
  jlps_bus_t bus_nxt;
  jlps_live_t live_s;
  jlps_eof_t eof_s;
  logic hready_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [IDX_W-1:0] wr_idx_r;
  logic [IDX_W-1:0] rd_idx_r;
  logic [7:0] did_r;
  logic [1:0] eof_sel_r;
  logic enable_r;
  logic enable_d_r;
  logic [1:0] mask_r;
  logic link_up_r;
  logic realign_r;
  logic realign_nxt;
  logic phase_r;
  logic phase_nxt;
  logic armed_r;
  logic armed_nxt;
  logic irq_r;
  logic [7:0] ila_octet_r;
  logic ila_ins_r;
  logic [7:0] eof_code_r;
  logic eof_ins_r;
  logic accept;
  logic rd_accept;
  logic wr_accept;
  logic wr_did;
  logic wr_eof;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_mask;
  logic en_rise;
  logic phase_evt;
  logic did_slot;
  logic [7:0] status_byte;
  logic [31:0] rd_word;

  // Live levels from pins pass two flops
  jlps_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i({sync_n_i, serializer_pll_lock_i, converter_pll_lock_i}),
    .sync_o(live_s)
  );

  jlps_eof_sel u_eof (
    .select_i(eof_sel_r),
    .link_enable_i(enable_r),
    .mode_64b66b_i(mode_64b66b_i),
    .frame_end_i(frame_end_i),
    .substitute_ok_i(substitute_ok_i),
    .eof_o(eof_s)
  );

  // Bus decode
  assign accept = hsel_i & htrans_i[HTRANS_ACTIVE] & hready_i & (bus_r == BUS_IDLE);
  assign rd_accept = accept & ~hwrite_i;
  assign wr_accept = accept & hwrite_i;
  assign wr_did = wr_pend_r & (wr_idx_r == IDX_DEVICE_ID);
  assign wr_eof = wr_pend_r & (wr_idx_r == IDX_EOF_SEL);
  assign wr_stat = wr_pend_r & (wr_idx_r == IDX_STATUS);
  assign wr_ctrl = wr_pend_r & (wr_idx_r == IDX_CTRL);
  assign wr_mask = wr_pend_r & (wr_idx_r == IDX_IRQ_MASK);

  // Sticky events; a set in the clearing cycle wins
  assign en_rise = enable_r & ~enable_d_r;
  assign phase_evt = sysref_evt_i & (armed_r | en_rise);
  assign armed_nxt = enable_r & ~phase_evt & (armed_r | en_rise);
  assign realign_nxt = sysref_realign_i | (realign_r & ~(wr_stat & hwdata_i[ST_REALIGN]));
  assign phase_nxt = phase_evt | (phase_r & ~(wr_stat & hwdata_i[ST_PHASE_SET]));
  assign did_slot = (ila_multiframe_i == ILA_DID_MF) & ila_did_slot_i;

  // Live bits have no storage, so status writes cannot touch them
  assign status_byte = {1'b0, link_up_r, live_s.sync_n, realign_r, phase_r,
                        live_s.spll_lock, 1'b0, live_s.cpll_lock};

  assign rd_word = (rd_idx_r == IDX_DEVICE_ID) ? {24'h000000, did_r} :
                   (rd_idx_r == IDX_EOF_SEL) ? {30'h00000000, eof_sel_r} :
                   (rd_idx_r == IDX_STATUS) ? {24'h000000, status_byte} :
                   (rd_idx_r == IDX_CTRL) ? {31'h00000000, enable_r} :
                   (rd_idx_r == IDX_IRQ_MASK) ?
                     {27'h0000000, mask_r, 3'h0} : RD_ZERO;

  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      BUS_IDLE: begin
        if (rd_accept && hits(haddr_i, idx_of(haddr_i))) begin
          bus_nxt = BUS_RD_FETCH;
        end
      end
      BUS_RD_FETCH: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  // Bus slave: writes zero wait, reads one wait
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      bus_r <= BUS_IDLE;
      hready_r <= 1'b1;
      hrdata_r <= RD_ZERO;
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
      rd_idx_r <= '0;
    end else begin
      bus_r <= bus_nxt;
      hready_r <= (bus_nxt == BUS_IDLE);
      wr_pend_r <= wr_accept & hits(haddr_i, idx_of(haddr_i));
      if (accept) begin
        wr_idx_r <= idx_of(haddr_i);
        rd_idx_r <= idx_of(haddr_i);
      end
      if (bus_r == BUS_RD_FETCH) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      did_r <= RST_DEVICE_ID;
      eof_sel_r <= RST_EOF_SEL;
      enable_r <= 1'b0;
      mask_r <= 2'h0;
    end else begin
      if (wr_did) begin
        did_r <= hwdata_i[7:0];
      end
      if (wr_eof) begin
        eof_sel_r <= hwdata_i[1:0];
      end
      if (wr_ctrl) begin
        enable_r <= hwdata_i[CTRL_ENABLE];
      end
      if (wr_mask) begin
        mask_r <= hwdata_i[ST_REALIGN:ST_PHASE_SET];
      end
    end
  end

  // Status and interrupt
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      enable_d_r <= 1'b0;
      link_up_r <= 1'b0;
      realign_r <= 1'b0;
      phase_r <= 1'b0;
      armed_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
      link_up_r <= link_up_i;
      realign_r <= realign_nxt;
      phase_r <= phase_nxt;
      armed_r <= armed_nxt;
      irq_r <= |({realign_nxt, phase_nxt} & mask_r);
    end
  end

  // Link-side outputs
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ila_octet_r <= 8'h00;
      ila_ins_r <= 1'b0;
      eof_code_r <= K28_7_CODE;
      eof_ins_r <= 1'b0;
    end else begin
      ila_ins_r <= did_slot;
      ila_octet_r <= did_slot ? did_r : 8'h00;
      eof_code_r <= eof_s.k_code;
      eof_ins_r <= eof_s.insert;
    end
  end

  assign hreadyout_o = hready_r;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign ila_octet_o = ila_octet_r;
  assign ila_octet_ins_o = ila_ins_r;
  assign eof_comma_o = eof_code_r;
  assign eof_insert_o = eof_ins_r;
  assign serial_link_enable_o = enable_r;
  assign irq_o = irq_r;

  chk_did_ila: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    did_slot |=> (ila_octet_ins_o && ila_octet_o == $past(did_r)))
    else $error("identifier not placed in alignment octet");

  chk_eof_code: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (eof_sel_r == EOF_K28_1) |=> (eof_comma_o == K28_1_CODE) || $changed(eof_sel_r))
    else $error("wrong end-of-frame comma");

  chk_eof_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    eof_insert_o |-> $past(frame_end_i && substitute_ok_i && enable_r))
    else $error("comma inserted without a permitted frame end");

  chk_eof_64b: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    mode_64b66b_i |=> !eof_insert_o)
    else $error("comma inserted in 64B/66B mode");

  chk_link_up: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##1 status_byte[ST_LINK_UP] == $past(link_up_i))
    else $error("link-up bit does not follow link");

  chk_sync_level: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##2 status_byte[ST_SYNC] == $past(sync_n_i, 2))
    else $error("SYNC bit does not follow pin");

  chk_realign_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (realign_r && !(wr_stat && hwdata_i[ST_REALIGN])) |=> realign_r)
    else $error("realign flag lost without clear");

  chk_phase_first: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (sysref_evt_i && armed_r) |=> (phase_r && !armed_r))
    else $error("first SYSREF did not set phase flag");

  chk_phase_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wr_stat && !phase_evt) |=> (phase_r == ($past(phase_r) && !$past(hwdata_i[ST_PHASE_SET]))))
    else $error("phase flag clear misbehaves");

  chk_pll_lock: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##2 (status_byte[ST_SPLL] == $past(serializer_pll_lock_i, 2))
      && (status_byte[ST_CPLL] == $past(converter_pll_lock_i, 2)))
    else $error("PLL lock bits do not follow pins");

  chk_irq_level: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##1 irq_o == |({realign_r, phase_r} & $past(mask_r)))
    else $error("interrupt level mismatch");

  chk_read_wait: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (rd_accept && hits(haddr_i, idx_of(haddr_i))) |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");

  chk_write_nowait: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    wr_accept |=> hreadyout_o)
    else $error("write inserted a wait state");

  chk_eof_default: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (eof_sel_r == EOF_K28_7) |=> (eof_comma_o == K28_7_CODE) || $changed(eof_sel_r))
    else $error("end-of-frame comma not the default");

  chk_eof_k285: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (eof_sel_r == EOF_K28_5) |=> (eof_comma_o == K28_5_CODE) || $changed(eof_sel_r))
    else $error("end-of-frame comma not the third choice");

  chk_ila_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !did_slot |=> !ila_octet_ins_o)
    else $error("identifier octet outside its slot");

  chk_realign_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sysref_realign_i |=> realign_r)
    else $error("realign event not captured");

  chk_realign_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wr_stat && hwdata_i[ST_REALIGN] && !sysref_realign_i) |=> !realign_r)
    else $error("realign flag not cleared by write");

  chk_phase_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (phase_r && !(wr_stat && hwdata_i[ST_PHASE_SET])) |=> phase_r)
    else $error("phase flag lost without clear");

  chk_phase_disarm: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !enable_r |=> !armed_r)
    else $error("phase capture armed while link disabled");

  cov_did_write: cover property (@(posedge core_clk_i) disable iff (!resetn_i) wr_did);
  cov_phase_set: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    phase_evt ##[1:20] wr_stat);
  cov_eof_ins: cover property (@(posedge core_clk_i) disable iff (!resetn_i) eof_insert_o);
  cov_irq: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $rose(irq_o));
  cov_realign_set: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(realign_r));
endmodule
`default_nettype wire

// ==== logic/jlps_sync2.sv ====
// Two-flop synchroniser for levels from outside the core clock.
// Assumes slowly changing levels; no pulse capture.
`timescale 1ns/10ps
`default_nettype none
module jlps_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule
`default_nettype wire
